// ==== pkg/rsx_pkg.sv ====
package rsx_pkg;

  // instruction selection
  typedef enum logic [1:0] {
    RSX_ROTATE_RIGHT_THROUGH_CARRY,
    RSX_SUBTRACT_WORK_FROM_FILE,
    RSX_SWAP_FILE_NIBBLES,
    RSX_POWER_DOWN
  } rsx_op_t;

  // one decoded instruction with its operand
  typedef struct packed {
    logic [7:0] file_data;
    logic [6:0] file_addr;
    logic dest;
    rsx_op_t op;
  } rsx_instr_t;

  // datapath result handed back to the core
  typedef struct packed {
    logic [7:0] value;
    logic [6:0] file_addr;
    logic to_file;
    logic to_work;
    logic [7:0] status;
  } rsx_result_t;

endpackage

// ==== pkg/rsx_regs.svh ====
`ifndef RSX_REGS_SVH
`define RSX_REGS_SVH

// register offsets (byte addresses, one word each)
`define RSX_OFF_CTRL 8'h00
`define RSX_OFF_OPER 8'h04
`define RSX_OFF_WORK 8'h08
`define RSX_OFF_STAT 8'h0C
`define RSX_OFF_RES 8'h10
`define RSX_OFF_WDOG 8'h14

// ctrl fields
`define RSX_CTRL_GO 0
`define RSX_CTRL_WAKE 1

// oper fields: opcode [1:0], dest [2], file addr [9:3], file data [17:10]
`define RSX_OPER_OP_LSB 0
`define RSX_OPER_DST 2
`define RSX_OPER_ADR_LSB 3
`define RSX_OPER_DAT_LSB 10

// status register bit positions
`define RSX_ST_C 0
`define RSX_ST_DC 1
`define RSX_ST_Z 2
`define RSX_ST_PD 3
`define RSX_ST_TO 4
`define RSX_ST_SLEEP 8

// reset values
`define RSX_STAT_RST 8'h18
`define RSX_WORK_RST 8'h00

// highest file register address
`define RSX_FILE_MAX 127

`endif

// ==== rtl/rsx_alu.sv ====
`timescale 1ns/1ps
`include "rsx_regs.svh"

module rsx_alu (
  // instruction and operands
  input wire rsx_pkg::rsx_instr_t i_instr,
  input wire logic [7:0] i_work,
  input wire logic [7:0] i_status,
  // combinational result
  output rsx_pkg::rsx_result_t o_result
);
  import rsx_pkg::*;

  logic [8:0] diff;
  logic [4:0] ldiff;

  // subtract as f + ~w + 1 so carry reads as no-borrow
  assign diff = {1'b0, i_instr.file_data} + {1'b0, ~i_work} + 9'h001;
  assign ldiff = {1'b0, i_instr.file_data[3:0]} + {1'b0, ~i_work[3:0]} + 5'h01;

  // per-instruction value, flags and destination
  always_comb begin
    o_result = '0;
    o_result.status = i_status;
    o_result.file_addr = i_instr.file_addr;
    unique case (i_instr.op)
      RSX_ROTATE_RIGHT_THROUGH_CARRY: begin
        o_result.value = {i_status[`RSX_ST_C], i_instr.file_data[7:1]};
        o_result.status[`RSX_ST_C] = i_instr.file_data[0];
        o_result.to_work = ~i_instr.dest;
        o_result.to_file = i_instr.dest;
      end
      RSX_SUBTRACT_WORK_FROM_FILE: begin
        o_result.value = diff[7:0];
        o_result.status[`RSX_ST_C] = diff[8];
        o_result.status[`RSX_ST_DC] = ldiff[4];
        o_result.status[`RSX_ST_Z] = (diff[7:0] == 8'h00);
        o_result.to_work = ~i_instr.dest;
        o_result.to_file = i_instr.dest;
      end
      RSX_SWAP_FILE_NIBBLES: begin
        o_result.value = {i_instr.file_data[3:0], i_instr.file_data[7:4]};
        o_result.to_work = ~i_instr.dest;
        o_result.to_file = i_instr.dest;
      end
      RSX_POWER_DOWN: begin
        // only the two power flags move
        o_result.status[`RSX_ST_PD] = 1'b0;
        o_result.status[`RSX_ST_TO] = 1'b1;
      end
    endcase
  end
endmodule

// ==== rtl/rsx_exec.sv ====
`timescale 1ns/1ps
`include "rsx_regs.svh"

module rsx_exec #(
  parameter int WDOG_WIDTH = 8,
  parameter int PRESC_WIDTH = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // file register write-back and core control
  output logic o_file_we,
  output logic [6:0] o_file_addr,
  output logic [7:0] o_file_data,
  output logic o_osc_run,
  output logic o_prefetch,
  output logic o_wdog_clear
);
  import rsx_pkg::*;

  // elaboration check: the read mux has room for 16 bits of each image
  if (WDOG_WIDTH < 1 || WDOG_WIDTH > 16 || PRESC_WIDTH < 1 || PRESC_WIDTH > 16) begin
    $error("rsx_exec: watchdog widths must be 1..16");
  end

  typedef enum logic [1:0] {
    RSX_RUN,
    RSX_ASLEEP
  } rsx_state_t;

  rsx_state_t state_reg;
  rsx_instr_t oper_reg;
  rsx_result_t result;
  logic [7:0] work_reg;
  logic [7:0] status_reg;
  logic [WDOG_WIDTH-1:0] watchdog_counter_reg;
  logic [PRESC_WIDTH-1:0] presc_reg;
  logic [31:0] rd_next;
  logic wr_en;
  logic rd_en;
  logic go;
  logic wake;
  logic exec;

  // word address decode used by read and write paths
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  assign wr_en = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
  assign rd_en = i_wb_cyc & i_wb_stb & ~i_wb_we & ~o_wb_ack;
  assign go = wr_en & hit(i_wb_adr, `RSX_OFF_CTRL) & i_wb_sel[0] & i_wb_dat[`RSX_CTRL_GO];
  assign wake = wr_en & hit(i_wb_adr, `RSX_OFF_CTRL) & i_wb_sel[0] & i_wb_dat[`RSX_CTRL_WAKE];
  // no instruction cycles while the oscillator is stopped
  assign exec = go & (state_reg == RSX_RUN);

  rsx_alu u_alu (
    .i_instr(oper_reg),
    .i_work(work_reg),
    .i_status(status_reg),
    .o_result(result)
  );

  // single-cycle ack; drops the cycle after it was given
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
    end
  end

  // operand register, written byte-wise
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oper_reg <= '0;
    end else if (wr_en && hit(i_wb_adr, `RSX_OFF_OPER)) begin
      if (i_wb_sel[0]) begin
        oper_reg.op <= rsx_op_t'(i_wb_dat[`RSX_OPER_OP_LSB +: 2]);
        oper_reg.dest <= i_wb_dat[`RSX_OPER_DST];
        oper_reg.file_addr[4:0] <= i_wb_dat[`RSX_OPER_ADR_LSB +: 5];
      end
      // fields straddle byte lanes, so each lane loads only its own bits
      if (i_wb_sel[1]) begin
        oper_reg.file_addr[6:5] <= i_wb_dat[`RSX_OPER_ADR_LSB + 5 +: 2];
        oper_reg.file_data[5:0] <= i_wb_dat[`RSX_OPER_DAT_LSB +: 6];
      end
      if (i_wb_sel[2]) begin
        oper_reg.file_data[7:6] <= i_wb_dat[`RSX_OPER_DAT_LSB + 6 +: 2];
      end
    end
  end

  // work register: software load or instruction result
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      work_reg <= `RSX_WORK_RST;
    end else if (exec && result.to_work) begin
      work_reg <= result.value;
    end else if (wr_en && hit(i_wb_adr, `RSX_OFF_WORK) && i_wb_sel[0]) begin
      work_reg <= i_wb_dat[7:0];
    end
  end

  // status flags; instruction update beats a software write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_reg <= `RSX_STAT_RST;
    end else if (exec) begin
      status_reg <= result.status;
    end else if (wr_en && hit(i_wb_adr, `RSX_OFF_STAT) && i_wb_sel[0]) begin
      status_reg <= i_wb_dat[7:0];
    end
  end

  // file write-back strobe, one cycle per instruction whose result goes to the file
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_file_we <= 1'b0;
      o_file_addr <= 7'h00;
      o_file_data <= 8'h00;
    end else begin
      o_file_we <= exec & result.to_file;
      if (exec) begin
        o_file_addr <= result.file_addr;
        o_file_data <= result.value;
      end
    end
  end

  // sleep state: oscillator off until software wakes it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= RSX_RUN;
      o_osc_run <= 1'b1;
    end else begin
      unique case (state_reg)
        RSX_RUN: begin
          if (exec && oper_reg.op == RSX_POWER_DOWN) begin
            state_reg <= RSX_ASLEEP;
            o_osc_run <= 1'b0;
          end
        end
        RSX_ASLEEP: begin
          if (wake) begin
            state_reg <= RSX_RUN;
            o_osc_run <= 1'b1;
          end
        end
        default: begin
          state_reg <= RSX_RUN;
          o_osc_run <= 1'b1;
        end
      endcase
    end
  end

  // prefetch of pc+1 while sleep executes; watchdog clear pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prefetch <= 1'b0;
      o_wdog_clear <= 1'b0;
    end else begin
      o_prefetch <= exec & (oper_reg.op == RSX_POWER_DOWN);
      o_wdog_clear <= exec & (oper_reg.op == RSX_POWER_DOWN);
    end
  end

  // watchdog and prescaler images: prescaler counts instruction
  // cycles, counter steps on prescaler wrap; both stop in sleep
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_reg <= '0;
      watchdog_counter_reg <= '0;
    end else if (exec && oper_reg.op == RSX_POWER_DOWN) begin
      presc_reg <= '0;
      watchdog_counter_reg <= '0;
    end else if (exec) begin
      presc_reg <= presc_reg + 1'b1;
      if (&presc_reg) begin
        watchdog_counter_reg <= watchdog_counter_reg + 1'b1;
      end
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (hit(i_wb_adr, `RSX_OFF_OPER)) begin
      rd_next[17:0] = {oper_reg.file_data, oper_reg.file_addr, oper_reg.dest, oper_reg.op};
    end else if (hit(i_wb_adr, `RSX_OFF_WORK)) begin
      rd_next[7:0] = work_reg;
    end else if (hit(i_wb_adr, `RSX_OFF_STAT)) begin
      rd_next[7:0] = status_reg;
      rd_next[`RSX_ST_SLEEP] = (state_reg == RSX_ASLEEP);
    end else if (hit(i_wb_adr, `RSX_OFF_RES)) begin
      rd_next[15:0] = {o_file_data, 1'b0, o_file_addr};
    end else if (hit(i_wb_adr, `RSX_OFF_WDOG)) begin
      // prescaler in the upper half, counter in the lower half
      rd_next[31:16] = 16'(presc_reg);
      rd_next[15:0] = 16'(watchdog_counter_reg);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (rd_en) begin
      o_wb_dat <= rd_next;
    end
  end
endmodule

// ==== sim/rsx_exec_monitor.sv ====
`timescale 1ns/1ps
module rsx_exec_monitor (
  // clock, reset and bus inputs
  input wire logic i_clk, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  // design outputs
  input wire logic o_wb_ack, o_file_we, o_osc_run, o_prefetch, o_wdog_clear
);
  // decoded control writes, held by the master until ack
  logic req, go, wake;
  assign req = i_wb_cyc && i_wb_stb;
  assign go = req && i_wb_we && i_wb_adr == 8'h00 && i_wb_dat[0];
  assign wake = req && i_wb_we && i_wb_adr == 8'h00 && i_wb_dat[1];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_ack_one; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_ack_due; req && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack_due: assert property (p_ack_due) else $error("ack late");
  property p_ack_cause; o_wb_ack |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_fwe_one; o_file_we |=> !o_file_we; endproperty
  a_fwe_one: assert property (p_fwe_one) else $error("file write too long");
  property p_fwe_cause; o_file_we |-> $past(go); endproperty
  a_fwe_cause: assert property (p_fwe_cause) else $error("file write uncaused");
  property p_osc_fall; $fell(o_osc_run) |-> $past(go); endproperty
  a_osc_fall: assert property (p_osc_fall) else $error("oscillator stopped uncaused");
  property p_osc_rise; $rose(o_osc_run) |-> $past(wake); endproperty
  a_osc_rise: assert property (p_osc_rise) else $error("woke without request");
  property p_quiet; !o_osc_run |-> !o_file_we; endproperty
  a_quiet: assert property (p_quiet) else $error("file write while asleep");
  property p_clr; o_wdog_clear |-> o_prefetch ##1 !o_wdog_clear; endproperty
  a_clr: assert property (p_clr) else $error("watchdog clear bad");
  c_fwe: cover property (o_file_we);
  c_sleep: cover property ($fell(o_osc_run));
  c_wake: cover property ($rose(o_osc_run));
endmodule
bind rsx_exec rsx_exec_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
  .o_wb_ack(o_wb_ack), .o_file_we(o_file_we), .o_osc_run(o_osc_run),
  .o_prefetch(o_prefetch), .o_wdog_clear(o_wdog_clear));

// ==== sim/rsx_exec_tb_top.sv ====
`timescale 1ns/1ps
module rsx_exec_tb_top;
  logic i_clk, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [7:0] i_wb_adr, o_file_data, work, res, w, fd;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat;
  logic o_wb_ack, o_file_we, o_osc_run, o_prefetch, o_wdog_clear, dst;
  logic [6:0] o_file_addr, fa;
  logic [4:0] st;
  logic [1:0] op;
  logic [63:0] e;
  logic [14:0] fq[$];
  logic [63:0] rq[$];
  int fails, total_checks, pulses;

  rsx_exec DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_file_we(o_file_we),
    .o_file_addr(o_file_addr), .o_file_data(o_file_data), .o_osc_run(o_osc_run),
    .o_prefetch(o_prefetch), .o_wdog_clear(o_wdog_clear));

  // 125 MHz clock
  initial begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic chk(input bit ok);
    total_checks++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: result differs", $time);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one classic cycle; waits for ack, only the watchdog ends a dead wait
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    i_wb_cyc <= 1;
    i_wb_stb <= 1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do begin
      @(posedge i_clk);
    end while (o_wb_ack !== 1'b1);
    i_wb_cyc <= 0;
    i_wb_stb <= 0;
    i_wb_we <= 0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, v);
    rq.push_back({m, v});
    wb(0, a, 32'h0);
  endtask

  // result watcher: oldest note against each file write or read ack
  always @(posedge i_clk) begin
    if (o_file_we === 1'b1) begin
      if (fq.size() == 0) chk(0);
      else chk({o_file_addr, o_file_data} === fq.pop_front());
    end
    // sleep pulses come as a pair, counted for the main sequence
    if (i_rst_n === 1'b1) begin
      if (o_prefetch === 1'b1 && o_wdog_clear === 1'b1) pulses++;
      else if (o_prefetch !== 1'b0 || o_wdog_clear !== 1'b0) chk(0);
    end
    if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) begin
      if (rq.size() == 0) chk(0);
      else begin
        e = rq.pop_front();
        chk((o_wb_dat & e[63:32]) === e[31:0]);
      end
    end
  end

  initial begin
    i_rst_n = 0; i_wb_cyc = 0; i_wb_stb = 0; i_wb_we = 0;
    i_wb_adr = 0; i_wb_sel = 4'hF; i_wb_dat = 0;
    fails = 0; total_checks = 0; pulses = 0;
    void'($urandom(15379));
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1;
    @(posedge i_clk);
    rd(8'h0C, 32'h1F, 32'h18);
    rd(8'h08, 32'hFF, 32'h0);
    work = 0;
    st = 5'h18;
    for (int i = 0; i < 24; i++) begin
      op = 2'(i % 3);
      dst = 1'($urandom);
      fa = (i == 1) ? 7'h7F : 7'($urandom);
      fd = 8'($urandom);
      w = (i == 4) ? fd : 8'($urandom);
      work = w;
      st[2:0] = 3'($urandom);
      wb(1, 8'h08, {24'h0, w});
      wb(1, 8'h0C, {27'h0, st});
      wb(1, 8'h04, {14'h0, fd, fa, dst, op});
      case (op)
        0: begin
          res = {st[0], fd[7:1]};
          st[0] = fd[0];
        end
        1: begin
          res = fd - w;
          st[2:0] = {res == 0, fd[3:0] >= w[3:0], fd >= w};
        end
        default: res = {fd[3:0], fd[7:4]};
      endcase
      if (dst) fq.push_back({fa, res});
      else work = res;
      wb(1, 8'h00, 32'h1);
      rd(8'h08, 32'hFF, {24'h0, work});
      rd(8'h0C, 32'h1F, {27'h0, st});
    end
    // sleep, then a go that must be refused while asleep
    wb(1, 8'h04, 32'h3);
    wb(1, 8'h00, 32'h1);
    chk(o_osc_run === 1'b0);
    chk(pulses == 1);
    rd(8'h14, 32'hFFFF_FFFF, 32'h0);
    rd(8'h0C, 32'h11F, {23'h0, 4'b1000, 2'b10, st[2:0]});
    wb(1, 8'h04, {14'h0, 8'hA5, 7'h05, 1'b1, 2'h2});
    wb(1, 8'h00, 32'h1);
    wb(1, 8'h00, 32'h2);
    chk(o_osc_run === 1'b1);
    // unmapped place: write dropped, read zero
    wb(1, 8'h1C, 32'hFF);
    rd(8'h1C, 32'hFFFF_FFFF, 32'h0);
    rd(8'h08, 32'hFF, {24'h0, work});
    chk(pulses == 1);
    wrap_up;
  end

  // watchdog: the run needs a few hundred cycles at most
  initial begin
    #100000;
    chk(0);
    wrap_up;
  end
endmodule
